// file: logic/host_enable_cfg.svh
`ifndef HOST_ENABLE_CFG_SVH
`define HOST_ENABLE_CFG_SVH
// ----------------------------------------------------------------------------
// port addresses
// ----------------------------------------------------------------------------
`define PORT_SETUP_CTRL       16'h46E8
`define PORT_LB_ENABLE        16'h03C3
`define PORT_GLOBAL_ENABLE    16'h0102
`define PORT_EXT_INDEX        16'h03D6
`define PORT_EXT_DATA         16'h03D7
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SETUP_ENABLE_BIT      3
`define SETUP_MODE_BIT        4
`define SLEEP_BIT             0
`define SETUP_DIS_BIT         7
`define EXT_INDEX_W           7
// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define SETUP_CTRL_MASK       8'h18
`define SLEEP_MASK            8'h01
`define REG8_RESET            8'h00
`define BYTE_ZERO             8'h00
// ----------------------------------------------------------------------------
// dword register window
// ----------------------------------------------------------------------------
`define DW_SLOTS_DEFINED      5'h0D
`define DW_FIXED_BIT          9
`define PCI_IO_BASE_LSB       10
`define PCI_MEM_BASE_LSB      23
`define PCI_MEM_FB_TOP        2'h0
`endif

// file: logic/host_enable_pkg.sv
package host_enable_pkg;
  // bus configuration strap
  typedef enum logic [1:0] {
    BUS_ISA   = 2'h0,
    BUS_LOCAL = 2'h1,
    BUS_PCI   = 2'h2
  } bus_cfg_t;
  // one host bus cycle
  typedef struct packed {
    logic        io_cycle;
    logic        mem_cycle;
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } host_req_t;
  // decode result
  typedef struct packed {
    logic       hit_ext;
    logic       hit_dword;
    logic [4:0] dword_slot;
    logic       dword_reserved;
    logic       hit_fb;
    logic       hit_vga;
  } decode_t;
endpackage

// file: logic/dword_window_decode.sv
`timescale 1ns/1ps
`include "host_enable_cfg.svh"
module dword_window_decode (
  input  wire host_enable_pkg::bus_cfg_t bus_cfg,
  input  wire host_enable_pkg::host_req_t req,
  input  wire logic [7:0]                isa_dw_base,
  input  wire logic [31:10]              pci_io_base,
  input  wire logic [31:23]              pci_mem_base,
  output logic                           hit_dword,
  output logic [4:0]                     slot,
  output logic                           reserved_slot,
  output logic                           hit_fb
);
  // isa/vl: pattern b nnnnn 1 bbbbbbb xx
  wire       isa_like  = bus_cfg != host_enable_pkg::BUS_PCI;
  wire [7:0] isa_b     = {req.addr[15], req.addr[8:2]};
  wire       isa_hit   = isa_like && req.io_cycle && (req.addr[31:16] == 16'h0000)
                         && req.addr[`DW_FIXED_BIT] && (isa_b == isa_dw_base);
  wire       pci       = bus_cfg == host_enable_pkg::BUS_PCI;
  wire       pci_io    = pci && req.io_cycle
                         && (req.addr[31:`PCI_IO_BASE_LSB] == pci_io_base);
  wire       pci_mwin  = pci && req.mem_cycle
                         && (req.addr[31:`PCI_MEM_BASE_LSB] == pci_mem_base);
  wire       pci_fb    = pci_mwin && (req.addr[22:21] == `PCI_MEM_FB_TOP);
  wire       pci_mreg  = pci_mwin && !pci_fb;
  wire [4:0] isa_slot  = req.addr[14:10];
  wire [4:0] pci_slot  = req.addr[6:2];
  assign hit_dword     = isa_hit || pci_io || pci_mreg;
  assign slot          = isa_hit ? isa_slot : pci_slot;
  assign reserved_slot = slot >= `DW_SLOTS_DEFINED;
  assign hit_fb        = pci_fb;
endmodule

// file: logic/host_access_enable_decode.sv
// Operation
// - setup port write-only, isa only, ignored when setup-disable bit set
// - reset clears the whole setup register
// - setup bit 3 enables controller, bit 4 selects setup mode
// - setup mode only entered under isa through setup port
// - local-bus enable port write-only, local bus only, blocked by setup-disable
// - reset disables; until bit 0 set only local-bus enable port and extension index/data pair decode
// - pci ignores local-bus enable; pci config controls enable instead
// - global enable port accessible only in setup mode
// - isa reset clears global bit 0; then only setup, global enable and extension index/data ports decode
// - isa enabled equals global bit 0 and setup bit 3
// - setup port writes keep decoding while controller disabled
// - extension index/data pair with seven-bit index always accessible
// - dword window has 32 slots, only first 13 defined
// - isa/vl dword address pattern matches base register bits
// - pci dword registers answer in 1KB io window and memory
// - pci 8MB window: low 2MB display memory, rest dword registers
// - all disable conditions are ORed; access needs none active
// - disabling blocks host access only, internal functions keep running
// - global enable decoded only at its full exact address
`timescale 1ns/1ps
`include "host_enable_cfg.svh"
module host_access_enable_decode (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire host_enable_pkg::bus_cfg_t bus_cfg_strap,
  input  wire host_enable_pkg::host_req_t req,
  input  wire logic                      req_valid,
  input  wire logic                      setup_disable,
  input  wire logic                      pci_io_en,
  input  wire logic                      pci_mem_en,
  input  wire logic [7:0]                isa_dw_base,
  input  wire logic [31:10]              pci_io_base,
  input  wire logic [31:23]              pci_mem_base,
  output logic                           ack,
  output logic [7:0]                     rdata,
  output host_enable_pkg::decode_t       hit,
  output logic                           access_enabled,
  output logic                           setup_mode,
  output logic [6:0]                     ext_index
);
  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  host_enable_pkg::bus_cfg_t bus_cfg_reg;
  logic                      cfg_taken_reg;
  logic [7:0]                setup_ctrl_reg;
  logic [7:0]                setup_ctrl_next;
  logic [7:0]                lb_enable_reg;
  logic [7:0]                lb_enable_next;
  logic [7:0]                global_enable_reg;
  logic [7:0]                global_enable_next;
  logic [6:0]                ext_index_reg;
  logic [6:0]                ext_index_next;
  logic                      ack_reg;
  logic [7:0]                rdata_reg;
  host_enable_pkg::decode_t  hit_reg;
  host_enable_pkg::decode_t  hit_next;
  logic                      enabled_reg;
  // --------------------------------------------------------------------------
  // address compare
  // --------------------------------------------------------------------------
  function automatic logic port_is(input logic [31:0] a, input logic [15:0] p);
    port_is = (a[31:16] == 16'h0000) && (a[15:0] == p);
  endfunction
  wire is_isa    = bus_cfg_reg == host_enable_pkg::BUS_ISA;
  wire is_local  = bus_cfg_reg == host_enable_pkg::BUS_LOCAL;
  wire is_pci    = bus_cfg_reg == host_enable_pkg::BUS_PCI;
  wire io_rq     = req_valid && req.io_cycle;
  wire io_wr     = io_rq && req.wr;
  wire io_rd     = io_rq && !req.wr;
  wire at_setup  = port_is(req.addr, `PORT_SETUP_CTRL);
  wire at_lb     = port_is(req.addr, `PORT_LB_ENABLE);
  wire at_global = port_is(req.addr, `PORT_GLOBAL_ENABLE);
  wire at_xidx   = port_is(req.addr, `PORT_EXT_INDEX);
  wire at_xdat   = port_is(req.addr, `PORT_EXT_DATA);
  wire in_setup  = setup_ctrl_reg[`SETUP_MODE_BIT];
  // --------------------------------------------------------------------------
  // enable combination
  // --------------------------------------------------------------------------
  wire isa_off   = !(global_enable_reg[`SLEEP_BIT] && setup_ctrl_reg[`SETUP_ENABLE_BIT]);
  wire lb_off    = !lb_enable_reg[`SLEEP_BIT];
  wire pci_off   = !(pci_io_en || pci_mem_en);
  wire any_off   = (is_isa && isa_off) || (is_local && lb_off) || (is_pci && pci_off);
  // --------------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------------
  wire wr_setup  = io_wr && at_setup && is_isa && !setup_disable;
  wire wr_lb     = io_wr && at_lb && is_local && !setup_disable;
  wire acc_glob  = io_rq && at_global && is_isa && in_setup;
  wire wr_glob   = acc_glob && req.wr;
  wire rd_glob   = acc_glob && !req.wr;
  wire xr_open   = io_rq && (at_xidx || at_xdat);
  assign setup_ctrl_next    = wr_setup ? (req.wdata & `SETUP_CTRL_MASK)
                                       : setup_ctrl_reg;
  assign lb_enable_next     = wr_lb ? (req.wdata & `SLEEP_MASK) : lb_enable_reg;
  assign global_enable_next = wr_glob ? (req.wdata & `SLEEP_MASK)
                                      : global_enable_reg;
  assign ext_index_next     = (io_wr && at_xidx) ? req.wdata[`EXT_INDEX_W-1:0]
                                                 : ext_index_reg;
  // --------------------------------------------------------------------------
  // window decode
  // --------------------------------------------------------------------------
  logic       dw_hit;
  logic [4:0] dw_slot;
  logic       dw_rsvd;
  logic       fb_hit;
  dword_window_decode u_dw (
    .bus_cfg       (bus_cfg_reg),
    .req           (req),
    .isa_dw_base   (isa_dw_base),
    .pci_io_base   (pci_io_base),
    .pci_mem_base  (pci_mem_base),
    .hit_dword     (dw_hit),
    .slot          (dw_slot),
    .reserved_slot (dw_rsvd),
    .hit_fb        (fb_hit)
  );
  wire ctrl_port = at_setup || at_lb || at_global;
  wire gate_ok   = req_valid && !any_off;
  wire pci_io_ok = !is_pci || !req.io_cycle || pci_io_en;
  wire pci_mm_ok = !is_pci || !req.mem_cycle || pci_mem_en;
  wire pass      = gate_ok && pci_io_ok && pci_mm_ok;
  assign hit_next.hit_ext        = xr_open && !any_off;
  assign hit_next.hit_dword      = pass && dw_hit;
  assign hit_next.dword_slot     = dw_slot;
  assign hit_next.dword_reserved = pass && dw_hit && dw_rsvd;
  assign hit_next.hit_fb         = pass && fb_hit;
  assign hit_next.hit_vga        = pass && !dw_hit && !fb_hit && !ctrl_port
                                   && !(req.io_cycle && (at_xidx || at_xdat));
  wire own_ack   = wr_setup || wr_lb || acc_glob;
  wire [7:0] rd_val = rd_glob ? global_enable_reg
                    : (io_rd && at_xidx) ? {1'b0, ext_index_reg}
                    : `BYTE_ZERO;
  // --------------------------------------------------------------------------
  // flip-flops
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_cfg_reg   <= host_enable_pkg::BUS_ISA;
      cfg_taken_reg <= 1'b0;
    end else if (!cfg_taken_reg) begin
      bus_cfg_reg   <= bus_cfg_strap;
      cfg_taken_reg <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_ctrl_reg    <= `REG8_RESET;
      lb_enable_reg     <= `REG8_RESET;
      global_enable_reg <= `REG8_RESET;
      ext_index_reg     <= 7'h00;
    end else begin
      setup_ctrl_reg    <= setup_ctrl_next;
      lb_enable_reg     <= lb_enable_next;
      global_enable_reg <= global_enable_next;
      ext_index_reg     <= ext_index_next;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= `BYTE_ZERO;
      hit_reg     <= '0;
      enabled_reg <= 1'b0;
    end else begin
      ack_reg     <= own_ack || xr_open;
      rdata_reg   <= rd_val;
      hit_reg     <= hit_next;
      enabled_reg <= !any_off;
    end
  end
  assign ack            = ack_reg;
  assign rdata          = rdata_reg;
  assign hit            = hit_reg;
  assign access_enabled = enabled_reg;
  assign setup_mode     = setup_ctrl_reg[`SETUP_MODE_BIT];
  assign ext_index      = ext_index_reg;
  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_setup_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (io_wr && at_setup && (setup_disable || !is_isa)) |=> $stable(setup_ctrl_reg))
    else $error("setup register changed while it should be ignored");
  a_setup_written: assert property (@(posedge clk) disable iff (!rst_n)
    wr_setup |=> setup_ctrl_reg == ($past(req.wdata) & `SETUP_CTRL_MASK))
    else $error("setup register did not take written bits");
  a_setup_isa_only: assert property (@(posedge clk) disable iff (!rst_n)
    (!is_isa && cfg_taken_reg) |-> ##1 !setup_mode)
    else $error("setup mode outside isa");
  a_lb_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    (io_wr && at_lb && (setup_disable || !is_local)) |=> $stable(lb_enable_reg))
    else $error("local-bus enable changed while blocked");
  a_lb_gate_vga: assert property (@(posedge clk) disable iff (!rst_n)
    (is_local && lb_off && req_valid) |=> !hit.hit_vga && !hit.hit_dword)
    else $error("access passed while local bus disabled");
  a_global_guard: assert property (@(posedge clk) disable iff (!rst_n)
    (io_wr && at_global && !in_setup) |=> $stable(global_enable_reg))
    else $error("global enable changed outside setup mode");
  a_isa_and: assert property (@(posedge clk) disable iff (!rst_n)
    (is_isa && cfg_taken_reg) |=> access_enabled ==
      ($past(global_enable_reg[0]) && $past(setup_ctrl_reg[3])))
    else $error("isa enable is not the and of both bits");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (setup_ctrl_reg[2:0] == 3'h0) && (lb_enable_reg[7:1] == 7'h00)
      && (global_enable_reg[7:1] == 7'h00))
    else $error("reserved enable bits not zero");
  a_xr_open: assert property (@(posedge clk) disable iff (!rst_n)
    xr_open |=> ack)
    else $error("extension port pair not answered");
  a_isa_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
    (is_isa && cfg_taken_reg && isa_off && req_valid)
      |=> !hit.hit_vga && !hit.hit_dword && !hit.hit_fb)
    else $error("access passed while isa controller disabled");
  a_pci_gate_off: assert property (@(posedge clk) disable iff (!rst_n)
    (is_pci && cfg_taken_reg && pci_off && req_valid)
      |=> !hit.hit_vga && !hit.hit_dword && !hit.hit_fb)
    else $error("access passed while pci controller disabled");
  a_setup_while_off: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_setup && isa_off) |=> ack)
    else $error("setup port not answered while disabled");
  a_cfg_held: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_taken_reg |=> $stable(bus_cfg_reg))
    else $error("bus configuration changed after reset");
  a_global_alias: assert property (@(posedge clk) disable iff (!rst_n)
    (io_wr && in_setup && (req.addr[2:0] == 3'h2)
      && (req.addr[15:0] != `PORT_GLOBAL_ENABLE)) |=> $stable(global_enable_reg))
    else $error("global enable written through an alias address");
  a_dword_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    hit.dword_reserved |-> hit.hit_dword && (hit.dword_slot >= `DW_SLOTS_DEFINED))
    else $error("reserved dword slot flagged wrongly");
  a_lb_written: assert property (@(posedge clk) disable iff (!rst_n)
    wr_lb |=> lb_enable_reg == ($past(req.wdata) & `SLEEP_MASK))
    else $error("local-bus enable did not take written bit");
endmodule

// file: verification/host_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// host cpu bus model: one byte cycle at a time
// ----------------------------------------------------------------------------
module host_bus_model (
  input  wire logic                       clk,
  input  wire logic                       ack,
  input  wire logic [7:0]                 rdata,
  input  wire host_enable_pkg::decode_t   hit,
  output host_enable_pkg::host_req_t      req,
  output logic                            req_valid
);
  logic                     got_ack;
  logic [7:0]               got_rdata;
  host_enable_pkg::decode_t got_hit;

  initial begin
    req       = '0;
    req_valid = 1'b0;
  end

  // one pulse of req_valid, answer taken one cycle later
  task automatic cyc(input logic io, input logic wr, input logic [31:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    #1;
    req       = '{io_cycle: io, mem_cycle: ~io, wr: wr, addr: a, wdata: d};
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    got_ack   = ack;
    got_rdata = rdata;
    got_hit   = hit;
    req_valid = 1'b0;
    // released lines show the inverse of the last wr, addr and wdata; io_cycle and mem_cycle clear
    req       = '{io_cycle: 1'b0, mem_cycle: 1'b0, wr: ~wr, addr: ~a, wdata: ~d};
  endtask
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("Error t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  logic                        clk;
  logic                        rst_n;
  host_enable_pkg::bus_cfg_t   bus_cfg_strap;
  host_enable_pkg::host_req_t  req;
  logic                        req_valid;
  logic                        setup_disable;
  logic                        pci_io_en;
  logic                        pci_mem_en;
  logic [7:0]                  isa_dw_base;
  logic [31:10]                pci_io_base;
  logic [31:23]                pci_mem_base;
  logic                        ack;
  logic [7:0]                  rdata;
  host_enable_pkg::decode_t    hit;
  logic                        access_enabled;
  logic                        setup_mode;
  logic [6:0]                  ext_index;
  int                          bad_count;
  int                          samples_checked;

  host_access_enable_decode i_dut (.clk(clk), .rst_n(rst_n), .bus_cfg_strap(bus_cfg_strap),
    .req(req), .req_valid(req_valid), .setup_disable(setup_disable), .pci_io_en(pci_io_en),
    .pci_mem_en(pci_mem_en), .isa_dw_base(isa_dw_base), .pci_io_base(pci_io_base),
    .pci_mem_base(pci_mem_base), .ack(ack), .rdata(rdata), .hit(hit),
    .access_enabled(access_enabled), .setup_mode(setup_mode), .ext_index(ext_index));
  host_bus_model i_host (.clk(clk), .ack(ack), .rdata(rdata), .hit(hit), .req(req),
    .req_valid(req_valid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  task automatic do_reset(input host_enable_pkg::bus_cfg_t cfg);
    rst_n         = 1'b0;
    bus_cfg_strap = cfg;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic settle();
    @(posedge clk);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task automatic t_isa();
    do_reset(host_enable_pkg::BUS_ISA);
    `CHK(access_enabled, 1'b0)
    `CHK(setup_mode, 1'b0)
    i_host.cyc(1, 1, 32'h0000_0102, 8'hFF);
    `CHK(i_host.got_ack, 1'b0)
    i_host.cyc(1, 1, 32'h0000_46E8, 8'hFF);
    `CHK(i_host.got_ack, 1'b1)
    settle();
    `CHK(setup_mode, 1'b1)
    `CHK(access_enabled, 1'b0)
    i_host.cyc(1, 1, 32'h0000_1102, 8'h01);
    `CHK(i_host.got_ack, 1'b0)
    i_host.cyc(1, 1, 32'h0000_0102, 8'hFF);
    `CHK(i_host.got_ack, 1'b1)
    i_host.cyc(1, 0, 32'h0000_0102, 8'h00);
    `CHK(i_host.got_rdata, 8'h01)
    settle();
    `CHK(access_enabled, 1'b1)
    i_host.cyc(1, 0, 32'h0000_0BD0, 8'h00);
    `CHK(i_host.got_hit.hit_dword, 1'b1)
    `CHK(i_host.got_hit.dword_slot, 5'h02)
    i_host.cyc(1, 0, 32'h0000_37D0, 8'h00);
    `CHK(i_host.got_hit.dword_reserved, 1'b1)
    i_host.cyc(1, 1, 32'h0000_46E8, 8'h10);
    settle();
    `CHK(access_enabled, 1'b0)
    i_host.cyc(1, 1, 32'h0000_03D6, 8'hFF);
    `CHK(i_host.got_ack, 1'b1)
    `CHK(ext_index, 7'h7F)
    `CHK(i_host.got_hit.hit_ext, 1'b0)
    i_host.cyc(1, 1, 32'h0000_46E8, 8'h18);
    `CHK(i_host.got_ack, 1'b1)
    settle();
    `CHK(access_enabled, 1'b1)
    i_host.cyc(1, 0, 32'h0000_03D6, 8'h00);
    `CHK(i_host.got_ack, 1'b1)
    `CHK(i_host.got_rdata, 8'h7F)
    `CHK(i_host.got_hit.hit_ext, 1'b1)
    i_host.cyc(1, 1, 32'h0000_03C3, 8'h00);
    `CHK(i_host.got_ack, 1'b0)
    setup_disable = 1'b1;
    i_host.cyc(1, 1, 32'h0000_46E8, 8'h00);
    `CHK(i_host.got_ack, 1'b0)
    settle();
    `CHK(access_enabled, 1'b1)
    setup_disable = 1'b0;
    $display("test isa done");
  endtask

  task automatic t_local();
    do_reset(host_enable_pkg::BUS_LOCAL);
    `CHK(access_enabled, 1'b0)
    i_host.cyc(1, 0, 32'h0000_03CC, 8'h00);
    `CHK(i_host.got_hit.hit_vga, 1'b0)
    i_host.cyc(1, 1, 32'h0000_46E8, 8'h18);
    `CHK(i_host.got_ack, 1'b0)
    settle();
    `CHK(setup_mode, 1'b0)
    i_host.cyc(1, 1, 32'h0000_03C3, 8'h01);
    `CHK(i_host.got_ack, 1'b1)
    settle();
    `CHK(access_enabled, 1'b1)
    i_host.cyc(1, 0, 32'h0000_03CC, 8'h00);
    `CHK(i_host.got_hit.hit_vga, 1'b1)
    setup_disable = 1'b1;
    i_host.cyc(1, 1, 32'h0000_03C3, 8'h00);
    `CHK(i_host.got_ack, 1'b0)
    settle();
    `CHK(access_enabled, 1'b1)
    setup_disable = 1'b0;
    i_host.cyc(1, 1, 32'h0000_03C3, 8'h00);
    settle();
    `CHK(access_enabled, 1'b0)
    $display("test local done");
  endtask

  task automatic t_pci();
    do_reset(host_enable_pkg::BUS_PCI);
    i_host.cyc(1, 1, 32'h0000_03C3, 8'h01);
    `CHK(i_host.got_ack, 1'b0)
    settle();
    `CHK(access_enabled, 1'b0)
    pci_io_en = 1'b1;
    settle();
    settle();
    `CHK(access_enabled, 1'b1)
    i_host.cyc(1, 0, 32'h0000_0414, 8'h00);
    `CHK(i_host.got_hit.dword_slot, 5'h05)
    `CHK(i_host.got_hit.hit_dword, 1'b1)
    pci_mem_en = 1'b1;
    i_host.cyc(0, 0, 32'h0080_0010, 8'h00);
    `CHK(i_host.got_hit.hit_fb, 1'b1)
    i_host.cyc(0, 0, 32'h00A0_0034, 8'h00);
    `CHK(i_host.got_hit.hit_dword, 1'b1)
    `CHK(i_host.got_hit.dword_reserved, 1'b1)
    pci_io_en = 1'b0;
    settle();
    settle();
    `CHK(access_enabled, 1'b1)
    pci_mem_en = 1'b0;
    settle();
    settle();
    `CHK(access_enabled, 1'b0)
    $display("test pci done");
  endtask

  initial begin
    bad_count       = 0;
    samples_checked = 0;
    rst_n           = 1'b0;
    bus_cfg_strap   = host_enable_pkg::BUS_ISA;
    setup_disable   = 1'b0;
    pci_io_en       = 1'b0;
    pci_mem_en      = 1'b0;
    isa_dw_base     = 8'h74;
    pci_io_base     = 22'h000001;
    pci_mem_base    = 9'h001;
    t_isa();
    t_local();
    t_pci();
    conclude();
  end

  initial begin
    #50000;
    bad_count++;
    conclude();
  end
endmodule
